/* File: src/brc_regs.svh */
// Constants of the parallel remote control port: codes, reset address, timing, correction factor.
// Assumes inclusion by bare name from design and checker files.
`ifndef BRC_REGS_SVH
`define BRC_REGS_SVH
// Status codes
`define BRC_ST_IN_RANGE 3'h0
`define BRC_ST_UNDER_LIN 3'h1
`define BRC_ST_OVER 3'h2
`define BRC_ST_UNDER_LOG 3'h3
`define BRC_ST_ZEROING 3'h4
// Range codes on the output
`define BRC_RNG_1 3'h1
`define BRC_RNG_2 3'h2
`define BRC_RNG_3 3'h3
`define BRC_RNG_4 3'h4
`define BRC_RNG_5 3'h5
// Range select input codes
`define BRC_SEL_STANDBY 3'h0
// Sequencer power-up address, 000 octal
`define BRC_SEQ_RESET 6'h00
// Print strobe low time in ns and in cycles at 40 MHz (25 ns)
`define BRC_STROBE_NS 1000
`define BRC_CLK_NS 25
`define BRC_STROBE_CYC ((`BRC_STROBE_NS + `BRC_CLK_NS - 1) / `BRC_CLK_NS)
// Correction factor applied when the override input is low
`define BRC_CAL_100 7'h64
`endif

/* File: src/brc_pkg.sv */
// Types of the parallel remote control port.
// Assumes brc_regs.svh holds the numeric constants.
package brc_pkg;
  // Measurement mode: bit 1 is the first mode input, bit 0 the second
  typedef enum logic [1:0] {
    BRC_MODE_REF = 2'b00,
    BRC_MODE_LIN = 2'b01,
    BRC_MODE_REL = 2'b10,
    BRC_MODE_LOG = 2'b11
  } brc_mode_e;
  // Trigger behaviour
  typedef enum logic [1:0] {
    BRC_TRIG_HOLD = 2'b00,
    BRC_TRIG_FREE = 2'b01,
    BRC_TRIG_SINGLE = 2'b10
  } brc_trig_e;
  // Programming inputs from the controller
  typedef struct packed {
    logic remote_sel_n;
    logic [2:0] range_sel;
    logic rate;
    logic trig_hold_n;
    logic cal_override_n;
    logic [1:0] mode_sel;
    logic zero_req_n;
  } brc_prog_s;
  // Front-panel controls
  typedef struct packed {
    logic [2:0] range_sel;
    logic trig_hold;
    logic [1:0] mode_sel;
    logic zero_req;
    logic [6:0] cal_pct;
  } brc_panel_s;
  // One measurement result from the analog front end
  typedef struct packed {
    logic neg;
    logic [15:0] digits;
    logic [3:0] exponent;
    logic under;
    logic over;
    logic [2:0] range;
  } brc_meas_s;
  // Data driven to the printer
  typedef struct packed {
    logic [2:0] status;
    logic [2:0] range_code;
    logic sign;
    logic [15:0] digits;
    logic [3:0] exponent;
    logic [1:0] mode_code;
  } brc_out_s;
endpackage

/* File: src/brc_sync.sv */
// Two-flop synchroniser bank for the programming pins.
// Assumes one clock; inputs are asynchronous pins.
`timescale 1ns/1ps
module brc_sync #(
  parameter int W = 10
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [W-1:0] rst_val_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] s1_ff;
  logic [W-1:0] s2_ff;
  logic [W-1:0] nxt_s1;
  logic [W-1:0] nxt_s2;
  // ---------------------------------------------------------------
  // Synchroniser stages
  // ---------------------------------------------------------------
  // Stages hold while clock enable is low
  always_comb begin
    nxt_s1 = ce_i ? d_i : s1_ff;
    nxt_s2 = ce_i ? s1_ff : s2_ff;
  end
  // Reset to all ones: idle level of pulled-up pins
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s1_ff <= '1;
      s2_ff <= '1;
    end else begin
      s1_ff <= nxt_s1;
      s2_ff <= nxt_s2;
    end
  end
  assign q_o = s2_ff;
endmodule

/* File: src/brc_port.sv */
// Parallel BCD remote control port of a bench power meter.
// Assumes a 40 MHz clock; pins from the controller and front panel are asynchronous.
// Functional notes
// - Status code 000 in range, 001 linear under, 010 over, 011 log under, 100 zeroing.
// - Range code 001..100 for ranges 1..4, 101 for range 5.
// - After each measurement, valid data then a high-to-low print strobe.
// - Remote select high obeys panel except the override input; low obeys programming inputs.
// - Remote range 000 standby, 001..011 ranges, 11x auto ranging.
// - Standby holds sequencer at address 000 octal, no measurement.
// - Remote triggering chosen from rate input and trigger-hold input.
// - Override low forces 100 percent correction; high uses panel switch.
// - Remote mode inputs 00 reference, 10 relative, 01 linear, 11 log.
// - Auto-zero runs while zero request input is low.
// - Reading is sign plus four 8421 BCD digits and negative exponent.
`timescale 1ns/1ps
`include "brc_regs.svh"
module brc_port (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire brc_pkg::brc_prog_s prog_i,
  input wire brc_pkg::brc_panel_s panel_i,
  input wire logic meas_done_i,
  input wire brc_pkg::brc_meas_s meas_i,
  output brc_pkg::brc_out_s data_o,
  output logic print_n_o,
  output logic meas_req_o,
  output logic auto_range_o,
  output logic [2:0] range_o,
  output brc_pkg::brc_trig_e trig_o,
  output brc_pkg::brc_mode_e mode_o,
  output logic [6:0] cal_pct_o,
  output logic zero_o,
  output logic standby_o,
  output logic [5:0] seq_addr_o
);
  import brc_pkg::*;

  localparam int PW = $bits(brc_prog_s);
  localparam int FW = $bits(brc_panel_s);
  localparam int SCNT = `BRC_STROBE_CYC;

  typedef enum logic [1:0] {
    BRC_ST_IDLE = 2'b00,
    BRC_ST_SETUP = 2'b01,
    BRC_ST_STROBE = 2'b10
  } brc_pst_e;

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  brc_prog_s prog_s;
  brc_panel_s panel_s;
  logic [PW-1:0] prog_raw;
  logic [FW-1:0] panel_raw;
  logic done_s;

  brc_sync #(.W(PW+FW+1)) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .rst_val_i('1),
    .d_i({prog_i, panel_i, meas_done_i}),
    .q_o({prog_raw, panel_raw, done_s})
  );
  assign prog_s = brc_prog_s'(prog_raw);
  assign panel_s = brc_panel_s'(panel_raw);

  // Maps a range number 1..5 to the output code
  function automatic logic [2:0] range_code(input logic [2:0] r);
    case (r)
      3'h1: range_code = `BRC_RNG_1;
      3'h2: range_code = `BRC_RNG_2;
      3'h3: range_code = `BRC_RNG_3;
      3'h4: range_code = `BRC_RNG_4;
      3'h5: range_code = `BRC_RNG_5;
      default: range_code = `BRC_RNG_1;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // Control selection
  // ---------------------------------------------------------------
  logic remote;
  logic [2:0] sel_range;
  logic sel_auto;
  logic sel_standby;
  brc_trig_e sel_trig;
  brc_mode_e sel_mode;
  logic [6:0] sel_cal;
  logic sel_zero;

  // Remote or panel source, then decode of range, trigger, mode and zero
  always_comb begin
    remote = ~prog_s.remote_sel_n;
    sel_range = remote ? prog_s.range_sel : panel_s.range_sel;
    sel_auto = remote && (prog_s.range_sel[2:1] == 2'b11);
    sel_standby = remote && (prog_s.range_sel == `BRC_SEL_STANDBY);
    if (!remote) begin
      sel_auto = (panel_s.range_sel[2:1] == 2'b11);
    end
    if (remote) begin
      if (!prog_s.trig_hold_n) begin
        sel_trig = BRC_TRIG_HOLD;
      end else if (prog_s.rate) begin
        sel_trig = BRC_TRIG_FREE;
      end else begin
        sel_trig = BRC_TRIG_SINGLE;
      end
      sel_mode = brc_mode_e'(prog_s.mode_sel);
      sel_zero = ~prog_s.zero_req_n;
    end else begin
      sel_trig = panel_s.trig_hold ? BRC_TRIG_HOLD : BRC_TRIG_FREE;
      sel_mode = brc_mode_e'(panel_s.mode_sel);
      sel_zero = panel_s.zero_req;
    end
    sel_cal = prog_s.cal_override_n ? panel_s.cal_pct : `BRC_CAL_100;
  end

  // ---------------------------------------------------------------
  // Registered controls and sequencer address
  // ---------------------------------------------------------------
  logic [5:0] seq_ff;
  logic [5:0] nxt_seq;
  logic done_d_ff;
  logic nxt_done_d;

  // Sequencer steps once per measurement, pinned to 000 in standby
  always_comb begin
    nxt_done_d = done_s;
    if (sel_standby) begin
      nxt_seq = `BRC_SEQ_RESET;
    end else if (done_s && !done_d_ff) begin
      nxt_seq = seq_ff + 6'h01;
    end else begin
      nxt_seq = seq_ff;
    end
  end
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      seq_ff <= `BRC_SEQ_RESET;
      done_d_ff <= 1'b1;
    end else if (ce_i) begin
      seq_ff <= nxt_seq;
      done_d_ff <= nxt_done_d;
    end
  end

  logic done_rise;
  assign done_rise = done_s && !done_d_ff && !sel_standby;

  // Control outputs
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      range_o <= 3'h0;
      auto_range_o <= 1'b1;
      trig_o <= BRC_TRIG_FREE;
      mode_o <= BRC_MODE_LIN;
      cal_pct_o <= `BRC_CAL_100;
      zero_o <= 1'b0;
      standby_o <= 1'b0;
    end else if (ce_i) begin
      range_o <= sel_range;
      auto_range_o <= sel_auto;
      trig_o <= sel_trig;
      mode_o <= sel_mode;
      cal_pct_o <= sel_cal;
      zero_o <= sel_zero;
      standby_o <= sel_standby;
    end
  end
  assign seq_addr_o = seq_ff;
  // Built from registered controls only, so it never leads standby or zero by a cycle
  assign meas_req_o = !standby_o && !zero_o && (trig_o != BRC_TRIG_HOLD);

  // ---------------------------------------------------------------
  // Output data and print strobe
  // ---------------------------------------------------------------
  brc_pst_e st_ff;
  brc_pst_e nxt_st;
  logic [7:0] cnt_ff;
  logic [7:0] nxt_cnt;
  brc_out_s out_ff;
  brc_out_s nxt_out;
  logic [2:0] nxt_status;

  // Status code of the latest result
  always_comb begin
    if (zero_o) begin
      nxt_status = `BRC_ST_ZEROING;
    end else if (meas_i.over) begin
      nxt_status = `BRC_ST_OVER;
    end else if (meas_i.under) begin
      nxt_status = (mode_o == BRC_MODE_LOG) ? `BRC_ST_UNDER_LOG : `BRC_ST_UNDER_LIN;
    end else begin
      nxt_status = `BRC_ST_IN_RANGE;
    end
  end

  // Latch data on completion, hold a setup cycle, then pulse print low
  always_comb begin
    nxt_st = st_ff;
    nxt_cnt = cnt_ff;
    nxt_out = out_ff;
    case (st_ff)
      BRC_ST_IDLE: begin
        if (done_rise) begin
          nxt_out.status = nxt_status;
          nxt_out.range_code = range_code(meas_i.range);
          nxt_out.sign = meas_i.neg;
          nxt_out.digits = meas_i.digits;
          nxt_out.exponent = meas_i.exponent;
          nxt_out.mode_code = mode_o;
          nxt_st = BRC_ST_SETUP;
        end
      end
      BRC_ST_SETUP: begin
        nxt_st = BRC_ST_STROBE;
        nxt_cnt = 8'(SCNT - 1);
      end
      BRC_ST_STROBE: begin
        if (cnt_ff == 8'h00) begin
          nxt_st = BRC_ST_IDLE;
        end else begin
          nxt_cnt = cnt_ff - 8'h01;
        end
      end
      default: nxt_st = BRC_ST_IDLE;
    endcase
  end
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_ff <= BRC_ST_IDLE;
      cnt_ff <= 8'h00;
      out_ff <= '0;
    end else if (ce_i) begin
      st_ff <= nxt_st;
      cnt_ff <= nxt_cnt;
      out_ff <= nxt_out;
    end
  end
  assign data_o = out_ff;
  assign print_n_o = (st_ff != BRC_ST_STROBE);
endmodule

/* File: tb/brc_port_assertions.sv */
// Checker for the remote control port.
// Assumes it is bound to brc_port; ce_i is lowered only while idle in local operation.
`timescale 1ns/1ps
`include "brc_regs.svh"
module brc_port_chk
  import brc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire brc_pkg::brc_prog_s prog_i,
  input wire brc_pkg::brc_out_s data_o,
  input wire logic print_n_o,
  input wire logic meas_req_o,
  input wire logic auto_range_o,
  input wire brc_pkg::brc_mode_e mode_o,
  input wire logic [6:0] cal_pct_o,
  input wire logic zero_o,
  input wire logic standby_o,
  input wire logic [5:0] seq_addr_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ----
  // Strobe and data
  // ----
  a_strobe_width: assert property (
    $fell(print_n_o) |-> ##39 !print_n_o ##1 print_n_o) else $error("strobe width wrong");
  a_data_held: assert property (
    !print_n_o |-> $stable(data_o)) else $error("data moved under strobe");
  // Steady remote pins reach the controls in three edges
  a_standby_set: assert property (
    (!prog_i.remote_sel_n && prog_i.range_sel == 3'h0 && $stable(prog_i))[*4] |-> standby_o)
    else $error("standby not entered");
  a_auto_set: assert property (
    (!prog_i.remote_sel_n && prog_i.range_sel[2:1] == 2'h3 && $stable(prog_i))[*4]
    |-> auto_range_o) else $error("auto range not set");
  a_mode_pick: assert property (
    (!prog_i.remote_sel_n && $stable(prog_i))[*4] |-> mode_o == brc_mode_e'(prog_i.mode_sel))
    else $error("mode not followed");
  a_zero_run: assert property (
    (!prog_i.remote_sel_n && !prog_i.zero_req_n && $stable(prog_i))[*4] |-> zero_o)
    else $error("zero not running");
  a_cal_force: assert property (
    (!prog_i.cal_override_n && $stable(prog_i))[*4] |-> cal_pct_o == `BRC_CAL_100)
    else $error("cal not forced");
  a_addr_home: assert property (
    standby_o && $past(standby_o) |-> seq_addr_o == `BRC_SEQ_RESET) else $error("seq moved");
  a_meas_gate: assert property (
    (!prog_i.remote_sel_n && (prog_i.range_sel == 3'h0 || !prog_i.zero_req_n)
    && $stable(prog_i))[*4] |-> !meas_req_o) else $error("measure while idle");
endmodule
bind brc_port brc_port_chk chk_u (.clk_i(clk_i), .rst_i(rst_i), .prog_i(prog_i),
  .data_o(data_o), .print_n_o(print_n_o), .meas_req_o(meas_req_o),
  .auto_range_o(auto_range_o), .mode_o(mode_o), .cal_pct_o(cal_pct_o), .zero_o(zero_o),
  .standby_o(standby_o), .seq_addr_o(seq_addr_o));

/* File: tb/brc_printer.sv */
// Printer model on the far side of the port.
// Assumes data is valid whenever the strobe falls.
`timescale 1ns/1ps
module brc_printer
  import brc_pkg::*;
(
  input wire logic print_n_i,
  input wire brc_pkg::brc_out_s data_i,
  output brc_pkg::brc_out_s cap_o,
  output int n_o
);
  // Take the word on each falling strobe
  initial begin
    cap_o = '0;
    n_o = 0;
  end
  always @(negedge print_n_i) begin
    cap_o <= data_i;
    n_o <= n_o + 1;
  end
endmodule

/* File: tb/brc_port_tb.sv */
// Self-checking bench for the remote control port.
// Assumes the design, package and printer model are compiled first.
`timescale 1ns/1ps
module brc_port_tb;
  import brc_pkg::*;
  logic clk_i, rst_i, ce, done, print_n, mreq, auto, zero, stby;
  brc_prog_s prog;
  brc_panel_s panel;
  brc_meas_s meas;
  brc_out_s data, cap;
  logic [2:0] rng;
  brc_trig_e trig;
  brc_mode_e mode;
  logic [6:0] cal;
  logic [5:0] addr;
  int fail_count, n_compared, n_pr;
  logic [2:0] st_x[5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h0};
  logic [2:0] rc_x[5] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5};
  logic [2:0] sel_x[6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h7};
  brc_port dut_u (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .prog_i(prog), .panel_i(panel),
    .meas_done_i(done), .meas_i(meas), .data_o(data), .print_n_o(print_n), .meas_req_o(mreq),
    .auto_range_o(auto), .range_o(rng), .trig_o(trig), .mode_o(mode), .cal_pct_o(cal),
    .zero_o(zero), .standby_o(stby), .seq_addr_o(addr));
  brc_printer prn_u (.print_n_i(print_n), .data_i(data), .cap_o(cap), .n_o(n_pr));
  // ----
  // Tasks
  // ----
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Drive pins, then let them settle through sync and register
  task automatic put(brc_prog_s p);
    prog <= p;
    repeat (5) @(posedge clk_i);
  endtask
  // One measurement; w returns the strobe low time in cycles
  task automatic run(brc_meas_s m, output int w);
    int k;
    k = 0;
    w = 0;
    meas <= m;
    done <= 1'b1;
    while (print_n !== 1'b0 && k < 20) begin
      @(posedge clk_i);
      k++;
    end
    while (print_n === 1'b0 && w < 60) begin
      @(posedge clk_i);
      w++;
    end
    done <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask
  task automatic close_out();
    if (fail_count == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Clock and watchdog
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  initial begin
    repeat (5000) @(posedge clk_i);
    fail_count++;
    close_out();
  end
  // ----
  // Main sequence
  // ----
  initial begin
    int w;
    brc_prog_s p;
    prog = '1;
    panel = '{range_sel: 3'h1, cal_pct: 7'h62, default: '0};
    meas = '0;
    done = 1'b0;
    ce = 1'b1;
    rst_i = 1'b1;
    repeat (12) @(posedge clk_i);
    chk("rst strobe", 1, print_n);
    chk("rst cal", 7'h64, cal);
    chk("rst trig", BRC_TRIG_FREE, trig);
    chk("rst seq", 0, addr);
    rst_i <= 1'b0;
    p = '{remote_sel_n: 0, range_sel: 3'h1, rate: 1, trig_hold_n: 1, cal_override_n: 1,
      mode_sel: 2'h1, zero_req_n: 1};
    // Every mode and range code, with under and over flags
    for (int i = 0; i < 5; i++) begin
      p.mode_sel = i[1:0];
      put(p);
      chk("mode", i[1:0], mode);
      run('{neg: i[0], digits: 16'h9870 + i[15:0], exponent: i[3:0] + 4'h1, under: i[0],
        over: i == 2, range: i[2:0] + 3'h1}, w);
      chk("strobe", 40, w);
      chk("prints", i + 1, n_pr);
      chk("status", st_x[i], cap.status);
      chk("range", rc_x[i], cap.range_code);
      chk("sign", i[0], cap.sign);
      chk("digits", 16'h9870 + i[15:0], cap.digits);
      chk("mode code", i[1:0], cap.mode_code);
      chk("exponent", i[3:0] + 4'h1, cap.exponent);
    end
    chk("seq count", 5, addr);
    // Range select codes, standby refuses a measurement
    foreach (sel_x[k]) begin
      p.range_sel = sel_x[k];
      put(p);
      chk("standby", sel_x[k] == 3'h0, stby);
      chk("auto", sel_x[k][2:1] == 2'h3, auto);
      if (k > 0 && k < 4) chk("range sel", sel_x[k], rng);
      if (k == 0) begin
        run('{range: 3'h1, default: '0}, w);
        chk("no strobe", 0, w);
        chk("seq home", 0, addr);
      end
    end
    p.range_sel = 3'h1;
    // Trigger decode
    for (int j = 0; j < 3; j++) begin
      {p.trig_hold_n, p.rate} = (j == 0) ? 2'h0 : ((j == 1) ? 2'h3 : 2'h2);
      put(p);
      chk("trig", j, trig);
      chk("meas req", j != 0, mreq);
    end
    p.cal_override_n = 1'b0;
    put(p);
    chk("cal", 7'h64, cal);
    p.cal_override_n = 1'b1;
    put(p);
    chk("cal", 7'h62, cal);
    // Zeroing beats overrange
    p.zero_req_n = 1'b0;
    put(p);
    chk("zero", 1, zero);
    chk("meas req", 0, mreq);
    run('{over: 1'b1, range: 3'h1, default: '0}, w);
    chk("status", 3'h4, cap.status);
    p.zero_req_n = 1'b1;
    put(p);
    chk("zero", 0, zero);
    // Controller settle time after zero, scaled down from seconds
    repeat (20) @(posedge clk_i);
    // Local operation follows the panel
    p.remote_sel_n = 1'b1;
    panel.mode_sel <= 2'h2;
    put(p);
    chk("local mode", BRC_MODE_REL, mode);
    run('{neg: 1'b1, digits: 16'h1234, exponent: 4'h2, range: 3'h5, default: '0}, w);
    chk("local strobe", 40, w);
    chk("local digits", 16'h1234, cap.digits);
    chk("local range", 3'h5, cap.range_code);
    chk("local mode code", 2'h2, cap.mode_code);
    // Clock enable low freezes the panel path
    ce <= 1'b0;
    panel.mode_sel <= 2'h3;
    repeat (5) @(posedge clk_i);
    chk("frozen mode", BRC_MODE_REL, mode);
    ce <= 1'b1;
    repeat (5) @(posedge clk_i);
    chk("thawed mode", BRC_MODE_LOG, mode);
    close_out();
  end
endmodule
